//--- design/spc_serial_ctrl.sv
// Serial port unit control register with request gating, filter and clock pin select
`timescale 1ns/1ns

// Summary of operation
// - Normal-mode meaning of bit 3 and bits 1:0 applies only while smartcard_select is 0; other fields keep it.
// - tx_empty_irq passes only while tx_irq_enable is 1.
// - rx_full_irq and rx_error_irq pass only while rx_irq_enable is 1.
// - Transmission runs only while tx_enable is 1.
// - Reception runs only while rx_enable is 1.
// - Bit 3 filter acts only in async mode with multiproc_mode_bit 1.
// - Filter drops characters with multiproc bit 0; no status flags set.
// - Character with multiproc bit 1 clears the filter bit; normal reception resumes.
// - Bit 2 passes tx_end_irq when 1, masks it otherwise.
// - Async, select 00: baud generator clock, clock pin released as port.
// - Async, select 01: baud generator clock, pin drives bit-rate clock.
// - Async, select 1X: pin supplies clock at sixteen times bit rate.
// - Sync, select 0X: internal clock, driven out on the pin.
// - Sync, select 1X: pin is clock input, shifting follows it.
module spc_serial_ctrl #(
	parameter int ADDR_W = spc_pkg::ADDR_W
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// Register port
	input wire logic [ADDR_W-1:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	// Events from transmitter and receiver
	input wire logic TX_EMPTY_EV_IN,
	input wire logic RX_FULL_EV_IN,
	input wire logic RX_ERR_EV_IN,
	input wire logic TX_END_EV_IN,
	// Gated interrupt requests
	output logic TX_EMPTY_IRQ_OUT,
	output logic RX_FULL_IRQ_OUT,
	output logic RX_ERR_IRQ_OUT,
	output logic TX_END_IRQ_OUT,
	output logic IRQ_OUT,
	// Transfer enables
	output logic TX_EN_OUT,
	output logic RX_EN_OUT,
	// Multiprocessor receive filter
	input wire logic RX_CHAR_DONE_IN,
	input wire logic RX_MPB_IN,
	output logic RX_FLAG_ALLOW_OUT,
	// Clock source and clock pin
	input wire logic BITCLK_IN,
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_OE_OUT,
	output logic SCK_PORT_RELEASE_OUT,
	output logic EXT_CLK_SEL_OUT,
	output logic SHIFT_CLK_OUT
);

	initial
	begin
		if (ADDR_W < 3 || ADDR_W > 16) $error("spc_serial_ctrl: ADDR_W out of range");
	end

	// ---------------------------------------------------------------
	// Decoding helpers
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [spc_pkg::ADDR_W-1:0] idx);
		hit = (a == ADDR_W'(idx));
	endfunction

	// Card mode keeps the pin released here; its own layout is not served
	function automatic spc_pkg::spc_pin_e pin_func(input spc_pkg::spc_mode_s m, input spc_pkg::spc_ctrl_s c);
		logic [1:0] sel;
		sel = {c.clk_src_sel_hi, c.clk_src_sel_lo};
		if (m.smartcard_select)
			pin_func = spc_pkg::PIN_PORT;
		else if (m.sync_mode)
			pin_func = c.clk_src_sel_hi ? spc_pkg::PIN_SYNC_IN : spc_pkg::PIN_SYNC_OUT;
		else if (sel == spc_pkg::CKSEL_BRG_PORT)
			pin_func = spc_pkg::PIN_PORT;
		else if (sel == spc_pkg::CKSEL_BRG_OUT)
			pin_func = spc_pkg::PIN_BIT_OUT;
		else
			pin_func = spc_pkg::PIN_EXT_16X;
	endfunction

	// ---------------------------------------------------------------
	// Registers and decode
	// ---------------------------------------------------------------
	spc_pkg::spc_ctrl_s ctrl_q;
	spc_pkg::spc_ctrl_s ctrl_d;
	spc_pkg::spc_mode_s mode_q;
	spc_pkg::spc_pin_e pin_fn;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic sck_q;
	logic sck_oe_q;
	logic shift_q;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic wr_mode;
	logic filter_active;
	logic mp_release;
	logic mp_discard;
	logic [3:0] ev;
	logic [3:0] en;
	logic [3:0] req;
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic irq;
	logic drive_pin;
	logic ext_clk;
	logic [7:0] state_word;

	assign wr_ctrl = WR_IN && hit(ADDR_IN, spc_pkg::IDX_CTRL);
	assign wr_stat = WR_IN && hit(ADDR_IN, spc_pkg::IDX_IRQ_STAT);
	assign wr_mask = WR_IN && hit(ADDR_IN, spc_pkg::IDX_IRQ_MASK);
	assign wr_mode = WR_IN && hit(ADDR_IN, spc_pkg::IDX_MODE);

	// Filter only in normal async mode with multiprocessor format
	assign filter_active = ctrl_q.multiproc_irq_enable && !mode_q.sync_mode
		&& mode_q.multiproc_mode_bit && !mode_q.smartcard_select;
	assign mp_discard = filter_active && RX_CHAR_DONE_IN && !RX_MPB_IN;
	assign mp_release = filter_active && RX_CHAR_DONE_IN && RX_MPB_IN;
	assign RX_FLAG_ALLOW_OUT = RX_EN_OUT && !mp_discard;

	// A software write wins over the hardware self-clear
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = spc_pkg::spc_ctrl_s'(WDATA_IN);
		else if (mp_release)
			ctrl_d.multiproc_irq_enable = 1'b0;
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			ctrl_q <= spc_pkg::spc_ctrl_s'(spc_pkg::CTRL_RESET);
		else
			ctrl_q <= ctrl_d;
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			mode_q <= spc_pkg::spc_mode_s'(spc_pkg::MODE_RESET);
		else if (wr_mode)
			mode_q <= spc_pkg::spc_mode_s'(WDATA_IN[2:0]);
	end

	// ---------------------------------------------------------------
	// Transfer enables and interrupt gating
	// ---------------------------------------------------------------
	assign TX_EN_OUT = ctrl_q.tx_enable;
	assign RX_EN_OUT = ctrl_q.rx_enable;

	assign ev[spc_pkg::EV_TX_EMPTY] = TX_EMPTY_EV_IN;
	assign ev[spc_pkg::EV_RX_FULL] = RX_FULL_EV_IN && !mp_discard;
	assign ev[spc_pkg::EV_RX_ERR] = RX_ERR_EV_IN && !mp_discard;
	assign ev[spc_pkg::EV_TX_END] = TX_END_EV_IN;
	assign en[spc_pkg::EV_TX_EMPTY] = ctrl_q.tx_irq_enable;
	assign en[spc_pkg::EV_RX_FULL] = ctrl_q.rx_irq_enable;
	assign en[spc_pkg::EV_RX_ERR] = ctrl_q.rx_irq_enable;
	assign en[spc_pkg::EV_TX_END] = ctrl_q.tx_end_irq_enable;

	spc_irq_gate #(
		.N(spc_pkg::NUM_EV)
	) u_irq (
		.clk_in(CLK_IN),
		.resetn_in(RESETN_IN),
		.ev_in(ev),
		.en_in(en),
		.clr_wr_in(wr_stat),
		.mask_wr_in(wr_mask),
		.wdata_in(WDATA_IN[3:0]),
		.req_out(req),
		.stat_out(irq_stat),
		.mask_out(irq_mask),
		.irq_out(irq)
	);

	assign TX_EMPTY_IRQ_OUT = req[spc_pkg::EV_TX_EMPTY];
	assign RX_FULL_IRQ_OUT = req[spc_pkg::EV_RX_FULL];
	assign RX_ERR_IRQ_OUT = req[spc_pkg::EV_RX_ERR];
	assign TX_END_IRQ_OUT = req[spc_pkg::EV_TX_END];
	assign IRQ_OUT = irq;

	// ---------------------------------------------------------------
	// Clock source and clock pin
	// ---------------------------------------------------------------
	assign pin_fn = pin_func(mode_q, ctrl_q);
	assign drive_pin = (pin_fn == spc_pkg::PIN_BIT_OUT) || (pin_fn == spc_pkg::PIN_SYNC_OUT);
	// Async external clock must run at 16x bit rate; sampling relies on it
	assign ext_clk = (pin_fn == spc_pkg::PIN_EXT_16X) || (pin_fn == spc_pkg::PIN_SYNC_IN);
	assign SCK_PORT_RELEASE_OUT = (pin_fn == spc_pkg::PIN_PORT);
	assign EXT_CLK_SEL_OUT = ext_clk;

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			sck_q <= 1'b0;
			sck_oe_q <= 1'b0;
			shift_q <= 1'b0;
		end
		else
		begin
			sck_q <= drive_pin ? BITCLK_IN : 1'b0;
			sck_oe_q <= drive_pin;
			shift_q <= ext_clk ? SCK_IN : BITCLK_IN;
		end
	end

	assign SCK_OUT = sck_q;
	assign SCK_OE_OUT = sck_oe_q;
	assign SHIFT_CLK_OUT = shift_q;

	// ---------------------------------------------------------------
	// Read path, data in the cycle after the strobe
	// ---------------------------------------------------------------
	assign state_word = {4'h0, irq, ext_clk, drive_pin, filter_active};

	always_comb
	begin
		rdata_d = 8'h00;
		if (RD_IN)
		begin
			if (hit(ADDR_IN, spc_pkg::IDX_CTRL))
				rdata_d = ctrl_q;
			else if (hit(ADDR_IN, spc_pkg::IDX_IRQ_STAT))
				rdata_d = {4'h0, irq_stat};
			else if (hit(ADDR_IN, spc_pkg::IDX_IRQ_MASK))
				rdata_d = {4'h0, irq_mask};
			else if (hit(ADDR_IN, spc_pkg::IDX_MODE))
				rdata_d = {5'h00, mode_q};
			else if (hit(ADDR_IN, spc_pkg::IDX_STATE))
				rdata_d = state_word;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign RDATA_OUT = rdata_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_tx_empty_gate;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		TX_EMPTY_EV_IN |-> (TX_EMPTY_IRQ_OUT == ctrl_q.tx_irq_enable);
	endproperty
	a_tx_empty_gate: assert property (p_tx_empty_gate) else $error("tx empty request gating wrong");

	property p_rx_gate;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(RX_FULL_IRQ_OUT || RX_ERR_IRQ_OUT) |-> ctrl_q.rx_irq_enable;
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("rx request passed while disabled");

	property p_tx_end_gate;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		wr_ctrl && !WDATA_IN[2] |=> !TX_END_IRQ_OUT;
	endproperty
	a_tx_end_gate: assert property (p_tx_end_gate) else $error("tx end request passed while disabled");

	property p_tx_enable;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		wr_ctrl |=> (TX_EN_OUT == $past(WDATA_IN[5]));
	endproperty
	a_tx_enable: assert property (p_tx_enable) else $error("transmit enable not following write");

	property p_rx_enable;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		wr_ctrl && !WDATA_IN[4] |=> !RX_EN_OUT && !RX_FLAG_ALLOW_OUT;
	endproperty
	a_rx_enable: assert property (p_rx_enable) else $error("reception active while disabled");

	property p_discard;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		filter_active && RX_CHAR_DONE_IN && !RX_MPB_IN && !wr_ctrl
			|-> !RX_FLAG_ALLOW_OUT && !RX_FULL_IRQ_OUT && !RX_ERR_IRQ_OUT ##1 ctrl_q.multiproc_irq_enable;
	endproperty
	a_discard: assert property (p_discard) else $error("filtered character not discarded");

	property p_mp_release;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		mp_release && !wr_ctrl |=> !ctrl_q.multiproc_irq_enable;
	endproperty
	a_mp_release: assert property (p_mp_release) else $error("filter bit not self-cleared");

	property p_filter_mode;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(mode_q.sync_mode || !mode_q.multiproc_mode_bit) |-> !filter_active;
	endproperty
	a_filter_mode: assert property (p_filter_mode) else $error("filter active outside async multiprocessor mode");

	property p_port_release;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		SCK_PORT_RELEASE_OUT ##1 SCK_PORT_RELEASE_OUT |-> !SCK_OE_OUT;
	endproperty
	a_port_release: assert property (p_port_release) else $error("pin driven while released");

	property p_sync_out;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		mode_q.sync_mode && !mode_q.smartcard_select && !ctrl_q.clk_src_sel_hi
			|=> SCK_OE_OUT && (SCK_OUT == $past(BITCLK_IN));
	endproperty
	a_sync_out: assert property (p_sync_out) else $error("sync internal clock not driven");

	property p_sync_in;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		mode_q.sync_mode && !mode_q.smartcard_select && ctrl_q.clk_src_sel_hi
			|=> !SCK_OE_OUT && (SHIFT_CLK_OUT == $past(SCK_IN));
	endproperty
	a_sync_in: assert property (p_sync_in) else $error("sync external clock not followed");

	property p_card_mode;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		mode_q.smartcard_select |-> !filter_active && SCK_PORT_RELEASE_OUT && !EXT_CLK_SEL_OUT;
	endproperty
	a_card_mode: assert property (p_card_mode) else $error("normal layout used in card mode");

	property p_bit_out;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		!mode_q.sync_mode && !mode_q.smartcard_select && !ctrl_q.clk_src_sel_hi && ctrl_q.clk_src_sel_lo
			|=> SCK_OE_OUT && (SCK_OUT == $past(BITCLK_IN));
	endproperty
	a_bit_out: assert property (p_bit_out) else $error("bit rate clock not driven");

	property p_ext_16x;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		!mode_q.sync_mode && !mode_q.smartcard_select && ctrl_q.clk_src_sel_hi
			|-> EXT_CLK_SEL_OUT && !SCK_PORT_RELEASE_OUT ##1 !SCK_OE_OUT;
	endproperty
	a_ext_16x: assert property (p_ext_16x) else $error("async external clock not taken");

	c_discard: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) mp_discard ##[1:50] mp_release);
	c_irq: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) TX_END_IRQ_OUT ##[1:20] IRQ_OUT);
	c_bit_out: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) (pin_fn == spc_pkg::PIN_BIT_OUT) && SCK_OUT);
	c_ext_clk: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) EXT_CLK_SEL_OUT && SHIFT_CLK_OUT);

endmodule // spc_serial_ctrl

//--- design/spc_pkg.sv
// Package for the serial port unit control register block
package spc_pkg;

	// ---------------------------------------------------------------
	// Register indices on the plain register port
	// ---------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] IDX_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_MODE = 4'h3;
	localparam logic [ADDR_W-1:0] IDX_STATE = 4'h4;

	// ---------------------------------------------------------------
	// Reset values and field positions
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam int MODE_SYNC_BIT = 0;
	localparam int MODE_MP_BIT = 1;
	localparam int MODE_SC_BIT = 2;
	localparam int EV_TX_EMPTY = 0;
	localparam int EV_RX_FULL = 1;
	localparam int EV_RX_ERR = 2;
	localparam int EV_TX_END = 3;
	localparam int NUM_EV = 4;
	localparam logic [1:0] CKSEL_BRG_PORT = 2'h0;
	localparam logic [1:0] CKSEL_BRG_OUT = 2'h1;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic tx_irq_enable;
		logic rx_irq_enable;
		logic tx_enable;
		logic rx_enable;
		logic multiproc_irq_enable;
		logic tx_end_irq_enable;
		logic clk_src_sel_hi;
		logic clk_src_sel_lo;
	} spc_ctrl_s;

	typedef struct packed {
		logic smartcard_select;
		logic multiproc_mode_bit;
		logic sync_mode;
	} spc_mode_s;

	typedef enum {
		PIN_PORT,
		PIN_BIT_OUT,
		PIN_EXT_16X,
		PIN_SYNC_OUT,
		PIN_SYNC_IN
	} spc_pin_e;

endpackage

//--- design/spc_irq_gate.sv
// Interrupt request gating with sticky status and mask
`timescale 1ns/1ns
module spc_irq_gate #(
	parameter int N = 4
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [N-1:0] ev_in,
	input wire logic [N-1:0] en_in,
	input wire logic clr_wr_in,
	input wire logic mask_wr_in,
	input wire logic [N-1:0] wdata_in,
	output logic [N-1:0] req_out,
	output logic [N-1:0] stat_out,
	output logic [N-1:0] mask_out,
	output logic irq_out
);

	logic [N-1:0] stat_q;
	logic [N-1:0] stat_d;
	logic [N-1:0] mask_q;

	initial
	begin
		if (N < 1 || N > 8) $error("spc_irq_gate: N out of range");
	end

	assign req_out = ev_in & en_in;
	assign stat_out = stat_q;
	assign mask_out = mask_q;
	assign irq_out = |(stat_q & mask_q);

	// Set beats write-one clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_bit
			assign stat_d[i] = req_out[i] || (stat_q[i] && !(clr_wr_in && wdata_in[i]));
		end
	endgenerate

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			stat_q <= '0;
		else
			stat_q <= stat_d;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			mask_q <= '0;
		else if (mask_wr_in)
			mask_q <= wdata_in;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_sticky_set;
		@(posedge clk_in) disable iff (!resetn_in)
		(|req_out) |=> (stat_q & $past(req_out)) == $past(req_out);
	endproperty
	a_sticky_set: assert property (p_sticky_set) else $error("request did not set status");

	property p_irq_level;
		@(posedge clk_in) disable iff (!resetn_in)
		irq_out |-> |(stat_q & mask_q);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq without unmasked status");

	property p_w1c_clear;
		@(posedge clk_in) disable iff (!resetn_in)
		clr_wr_in |=> (stat_q & $past(wdata_in) & ~$past(req_out)) == '0;
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear status");

endmodule // spc_irq_gate

//--- bench/spc_remote_model.sv
// Far-end serial party: supplies the external clock and received characters
`timescale 1ns/1ns
module spc_remote_model (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic sck_run_in,
	input wire logic send_in,
	input wire logic mpb_in,
	output logic sck_out,
	output logic done_out,
	output logic mpb_out
);
	// ---------------------------------------------------------------
	// External clock and received characters
	// ---------------------------------------------------------------
	// Clock stands still between frames; it only runs when asked
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sck_out <= 1'b0;
			done_out <= 1'b0;
			mpb_out <= 1'b0;
		end
		else
		begin
			sck_out <= sck_run_in ? ~sck_out : 1'b0;
			done_out <= send_in;
			// Outside a character the bit line toggles every cycle, not a stale value
			mpb_out <= send_in ? mpb_in : ~mpb_out;
		end
	end
endmodule // spc_remote_model

//--- bench/tb_spc_serial_ctrl.sv
// Self-checking bench for the serial port unit control register
`timescale 1ns/1ns
module tb_spc_serial_ctrl;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [2:0] mode;
		logic [8:0] exp;
	} spc_row_s;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [3:0] ev = 4'h0;
	logic bitclk = 1'b0;
	logic sck_run = 1'b0;
	logic send = 1'b0;
	logic mpb = 1'b0;
	logic [7:0] rdata;
	logic [3:0] irq;
	logic irq_any, tx_en, rx_en, allow, sck_o, sck_oe, release_p, ext_sel, shift_clk, done, mpb_l, sck_i;
	logic [7:0] d;
	int miscompares = 0;
	int tests_run = 0;
	spc_row_s rows [14] = '{
		'{8'h00, 3'h0, 9'b0000_00100}, '{8'h80, 3'h0, 9'b1000_00100}, '{8'h40, 3'h0, 9'b0110_00100},
		'{8'h04, 3'h0, 9'b0001_00100}, '{8'h20, 3'h0, 9'b0000_10100}, '{8'h10, 3'h0, 9'b0000_01100},
		'{8'h01, 3'h0, 9'b0000_00001}, '{8'h02, 3'h0, 9'b0000_00010}, '{8'h03, 3'h0, 9'b0000_00010},
		'{8'h00, 3'h1, 9'b0000_00001}, '{8'h01, 3'h1, 9'b0000_00001}, '{8'h02, 3'h1, 9'b0000_00010},
		'{8'h03, 3'h4, 9'b0000_00100}, '{8'hf4, 3'h4, 9'b1111_11100}};
	logic [4:0] cks [4] = '{5'b001_1_0, 5'b010_0_1, 5'b100_1_0, 5'b110_0_1};

	always #10 clk = ~clk;
	always @(posedge clk) bitclk <= ~bitclk;

	spc_serial_ctrl i_spc_serial_ctrl (.CLK_IN(clk), .RESETN_IN(resetn), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .TX_EMPTY_EV_IN(ev[3]), .RX_FULL_EV_IN(ev[2]),
		.RX_ERR_EV_IN(ev[1]), .TX_END_EV_IN(ev[0]), .TX_EMPTY_IRQ_OUT(irq[3]), .RX_FULL_IRQ_OUT(irq[2]),
		.RX_ERR_IRQ_OUT(irq[1]), .TX_END_IRQ_OUT(irq[0]), .IRQ_OUT(irq_any), .TX_EN_OUT(tx_en),
		.RX_EN_OUT(rx_en), .RX_CHAR_DONE_IN(done), .RX_MPB_IN(mpb_l), .RX_FLAG_ALLOW_OUT(allow),
		.BITCLK_IN(bitclk), .SCK_IN(sck_i), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe),
		.SCK_PORT_RELEASE_OUT(release_p), .EXT_CLK_SEL_OUT(ext_sel), .SHIFT_CLK_OUT(shift_clk));

	spc_remote_model i_spc_remote_model (.clk_in(clk), .resetn_in(resetn), .sck_run_in(sck_run),
		.send_in(send), .mpb_in(mpb), .sck_out(sck_i), .done_out(done), .mpb_out(mpb_l));

	// ---------------------------------------------------------------
	// Bus cycles and comparison
	// ---------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic pulse(input logic [3:0] e);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= 4'h0;
		#1;
	endtask

	// One received character; receive-full and receive-error events ride on the same cycle
	task automatic rx_char(input logic b, input logic exp_allow);
		@(posedge clk);
		send <= 1'b1;
		mpb <= b;
		@(posedge clk);
		send <= 1'b0;
		ev <= 4'h6;
		#1;
		chk("flag allow", allow, exp_allow);
		chk("rx full irq", irq[2], exp_allow);
		chk("rx error irq", irq[1], exp_allow);
		@(posedge clk);
		ev <= 4'h0;
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#200000;
		miscompares++;
		end_sim;
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		logic pb, ps;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk("reset pins", {release_p, sck_oe, tx_en, rx_en, irq_any}, 5'b10000);
		rd(spc_pkg::IDX_CTRL, d);
		chk("control reset", d, spc_pkg::CTRL_RESET);
		foreach (rows[i])
		begin
			wr(spc_pkg::IDX_MODE, {5'h00, rows[i].mode});
			wr(spc_pkg::IDX_CTRL, rows[i].ctrl);
			@(posedge clk);
			ev <= 4'hf;
			#1;
			chk("pin functions", {irq, tx_en, rx_en, release_p, ext_sel, sck_oe}, rows[i].exp);
			@(posedge clk);
			ev <= 4'h0;
			rd(spc_pkg::IDX_CTRL, d);
			chk("control readback", d, rows[i].ctrl);
			wr(spc_pkg::IDX_IRQ_STAT, 8'h0f);
		end
		// Clock pin: mode, select, driven, external
		foreach (cks[i])
		begin
			sck_run <= cks[i][0];
			wr(spc_pkg::IDX_MODE, {7'h00, cks[i][4]});
			wr(spc_pkg::IDX_CTRL, {6'h00, cks[i][3:2]});
			repeat (6)
			begin
				@(negedge clk);
				pb = bitclk;
				ps = sck_i;
				@(posedge clk);
				#1;
				chk("sck out", sck_o, pb & cks[i][1]);
				chk("shift clock", shift_clk, cks[i][0] ? ps : pb);
			end
			rd(spc_pkg::IDX_STATE, d);
			chk("state word", d, {5'h00, cks[i][0], cks[i][1], 1'b0});
			sck_run <= 1'b0;
		end
		// Multiprocessor filter
		wr(spc_pkg::IDX_MODE, 8'h02);
		wr(spc_pkg::IDX_CTRL, 8'h58);
		wr(spc_pkg::IDX_IRQ_STAT, 8'h0f);
		rx_char(1'b0, 1'b0);
		rx_char(1'b0, 1'b0);
		rd(spc_pkg::IDX_IRQ_STAT, d);
		chk("status after skip", d, 8'h00);
		rx_char(1'b1, 1'b1);
		rd(spc_pkg::IDX_CTRL, d);
		chk("filter self clear", d, 8'h50);
		rx_char(1'b0, 1'b1);
		rd(spc_pkg::IDX_IRQ_STAT, d);
		chk("status resumed", d, 8'h06);
		wr(spc_pkg::IDX_MODE, 8'h03);
		wr(spc_pkg::IDX_CTRL, 8'h58);
		rx_char(1'b0, 1'b1);
		wr(spc_pkg::IDX_MODE, 8'h00);
		rx_char(1'b0, 1'b1);
		// Sticky status, mask and clear
		wr(spc_pkg::IDX_IRQ_STAT, 8'h0f);
		wr(spc_pkg::IDX_IRQ_MASK, 8'h08);
		wr(spc_pkg::IDX_CTRL, 8'h04);
		pulse(4'h1);
		chk("irq raised", irq_any, 1'b1);
		rd(spc_pkg::IDX_IRQ_STAT, d);
		chk("status set", d, 8'h08);
		wr(spc_pkg::IDX_IRQ_STAT, 8'h08);
		#1;
		chk("irq cleared", irq_any, 1'b0);
		wr(spc_pkg::IDX_IRQ_MASK, 8'h00);
		pulse(4'h1);
		chk("irq masked", irq_any, 1'b0);
		rd(spc_pkg::IDX_IRQ_STAT, d);
		chk("masked status", d, 8'h08);
		wr(spc_pkg::IDX_IRQ_STAT, 8'h08);
		wr(spc_pkg::IDX_CTRL, 8'h00);
		pulse(4'h8);
		rd(spc_pkg::IDX_IRQ_STAT, d);
		chk("disabled event", d, 8'h00);
		// Unmapped and read-only places
		rd(4'hf, d);
		chk("unmapped read", d, 8'h00);
		wr(4'hf, 8'hff);
		wr(spc_pkg::IDX_STATE, 8'hff);
		rd(spc_pkg::IDX_CTRL, d);
		chk("control untouched", d, 8'h00);
		// Reset in mid-run
		wr(spc_pkg::IDX_CTRL, 8'hf5);
		@(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		resetn <= 1'b1;
		rd(spc_pkg::IDX_CTRL, d);
		chk("control after reset", d, spc_pkg::CTRL_RESET);
		chk("pins after reset", {release_p, sck_oe, tx_en, rx_en, irq_any}, 5'b10000);
		end_sim;
	end
endmodule // tb_spc_serial_ctrl
